// ### include/pstage_pkg.sv
/*
 Constants, register map and shared helpers of the programmable stage.
 Assumes a 50 MHz pclk and measurements in signed units of 0.0001.
*/
package pstage_pkg;
    // Clock and processing cycle
    localparam int CLK_HZ = 50_000_000;
    localparam int PROG_CYCLE_MS = 5;
    localparam int CYCLE_CLKS_DEF = CLK_HZ / 1000 * PROG_CYCLE_MS;
    localparam int DELTA_MS = 20;
    localparam int DELTA_DEPTH = DELTA_MS / PROG_CYCLE_MS;
    localparam int OP_DLY_MS = 40;
    localparam int REL_DLY_MS = 60;
    localparam int MAX_DLY_MS = 1_800_000;
    localparam logic [18:0] OP_DLY_RST = 19'(OP_DLY_MS / PROG_CYCLE_MS);
    localparam logic [18:0] REL_DLY_RST = 19'(REL_DLY_MS / PROG_CYCLE_MS);
    localparam logic [18:0] MAX_DLY_TICKS = 19'(MAX_DLY_MS / PROG_CYCLE_MS);
    localparam int NCH = 4;

    // Setting reset values and scales
    localparam logic [31:0] PICK_RST = 32'h0000_0064;
    localparam logic [31:0] HYST_RST = 32'h0000_7530;
    localparam logic [31:0] MULT_RST = 32'h0001_0000;
    localparam logic [31:0] LIM_RST = 32'h8000_0000;
    localparam logic [3:0] EN_RST = 4'h1;
    localparam logic signed [63:0] HYST_FULL = 64'sd1000000;
    localparam logic signed [63:0] REL_SCALE = 64'sd1000000;
    localparam logic signed [63:0] RATIO_ONE = 64'sd10000;
    localparam int MULT_FRAC = 16;

    // Register map, byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OPDLY = 8'h04;
    localparam logic [7:0] A_RELDLY = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam logic [7:0] A_REMAIN = 8'h10;
    localparam logic [7:0] A_EXPECT = 8'h14;
    localparam logic [7:0] A_CH_BASE = 8'h20;
    localparam logic [7:0] A_CH_END = 8'hA0;
    localparam logic [4:0] F_MODE = 5'h00;
    localparam logic [4:0] F_PICK = 5'h04;
    localparam logic [4:0] F_HYST = 5'h08;
    localparam logic [4:0] F_MULT = 5'h0C;
    localparam logic [4:0] F_LIM = 5'h10;
    localparam logic [4:0] F_SCALED = 5'h14;
    localparam logic [4:0] F_RATIO = 5'h18;

    typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} cond_t;

    function automatic logic signed [31:0] abs_val(input logic signed [31:0] v);
        abs_val = v[31] ? -v : v;
    endfunction
endpackage

// ### rtl/stage_comparator.sv
/*
 One comparison channel: comparator modes with per-level hysteresis.
 Assumes values and levels share units; old_value is the sample 20 ms back.
*/
module stage_comparator
    import pstage_pkg::*;
(
    input wire logic [2:0] mode,
    input wire logic signed [31:0] pickup,
    input wire logic signed [31:0] hyst,
    input wire logic signed [31:0] limit,
    input wire logic signed [31:0] value,
    input wire logic signed [31:0] old_value,
    input wire logic active,
    output logic fulfilled
);
    logic signed [63:0] h;
    logic signed [63:0] pk;
    logic signed [63:0] over_lvl;
    logic signed [63:0] under_lvl;
    logic signed [63:0] mag_lvl;
    logic signed [63:0] v;
    logic signed [63:0] a;
    logic signed [63:0] d;
    logic signed [63:0] dabs;
    logic signed [63:0] ao;

    always_comb
    begin
        pk = 64'(pickup);
        // Hysteresis widens only the release side of an active level
        h = (64'(abs_val(pickup)) * 64'(hyst)) / HYST_FULL;
        over_lvl = active ? pk - h : pk;
        under_lvl = active ? pk + h : pk;
        mag_lvl = active ? 64'(abs_val(pickup)) - h : 64'(abs_val(pickup));
        v = 64'(value);
        a = 64'(abs_val(value));
        d = v - 64'(old_value);
        dabs = d[63] ? -d : d;
        ao = 64'(abs_val(old_value));
        case (mode)
            3'h0: fulfilled = v > over_lvl;
            3'h1: fulfilled = a > over_lvl;
            3'h2: fulfilled = (v < under_lvl) && (v >= 64'(limit));
            3'h3: fulfilled = (a < under_lvl) && (a >= 64'(limit));
            3'h4: fulfilled = pk[63] ? (d * REL_SCALE < under_lvl * ao)
                                     : (d * REL_SCALE > over_lvl * ao);
            3'h5: fulfilled = dabs * REL_SCALE > mag_lvl * ao;
            3'h6: fulfilled = pk[63] ? (d < under_lvl) : (d > over_lvl);
            3'h7: fulfilled = dabs > mag_lvl;
            default: fulfilled = 1'b0;
        endcase
    end
endmodule

// ### rtl/programmable_stage_function.sv
/*
 Programmable protection stage: scaling, four comparators, operate and
 release timing, status, APB register file.
 Assumes measurement inputs synchronous to pclk and held between cycles.
*/
// The APB register port and the register offsets were decided locally.
// What this block does
// - Condition reported as 0 normal, 1 start, 2 trip, 3 blocked.
// - Remaining time to trip shown while timing, 0 to 1800 s.
// - Expected operating time shown as signed time value.
// - Each measurement times its multiplier gives the compared, readable value.
// - Ratio of each magnitude to its pick-up is computed and readable.
// - Each comparison has an eight-code mode, default over.
// - Pick-up levels are signed, 0.0001 steps, default 0.01.
// - Hysteresis is a percentage of pick-up, 0.0001 steps, default 3.
// - Every pick-up level has its own hysteresis setting.
// - Definite operate delay, 5 ms steps, default 40 ms, precedes trip.
// - Release delay, default 60 ms, precedes releasing the pick-up.
// - Pick-up gives start only while blocking is inactive.
// - Mode 0 fulfils when signed value exceeds pick-up.
// - Mode 1 fulfils when absolute value exceeds pick-up.
// - Mode 2 fulfils when signed value is below pick-up.
// - Mode 3 fulfils when absolute value is below pick-up.
// - Under modes are inactive while the value is below blocking limit.
// - Mode 4 fulfils on relative 20 ms change past pick-up, directed.
// - Mode 5 fulfils on relative 20 ms change past pick-up, either way.
// - Mode 6 fulfils on 20 ms change past pick-up, directed.
// - Mode 7 fulfils on 20 ms change past pick-up, either way.
// - Blocking sampled each cycle; active start resets when blocking asserts.
module programmable_stage_function
    import pstage_pkg::*;
#(
    parameter int CYCLE_CLKS = pstage_pkg::CYCLE_CLKS_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [31:0] meas_value_a,
    input wire logic signed [31:0] meas_value_b,
    input wire logic signed [31:0] meas_value_c,
    input wire logic signed [31:0] calculated_magnitude,
    input wire logic block_in,
    output pstage_pkg::cond_t condition,
    output logic start_out,
    output logic trip_out,
    output logic blocked_out,
    output logic [31:0] remaining_ms,
    output logic signed [31:0] expected_ms
);
    import pstage_pkg::*;

    localparam int HW = $clog2(DELTA_DEPTH);

    typedef struct packed {
        cond_t st;
        logic [17:0] div;
        logic tick;
        logic [18:0] op_cnt;
        logic [18:0] rel_cnt;
        logic [18:0] op_dly;
        logic [18:0] rel_dly;
        logic [3:0] en;
        logic [3:0] act;
        logic [NCH-1:0][2:0] mode;
        logic [NCH-1:0][31:0] pick;
        logic [NCH-1:0][31:0] hyst;
        logic [NCH-1:0][31:0] mult;
        logic [NCH-1:0][31:0] lim;
        logic [NCH-1:0][31:0] scaled;
        logic [NCH-1:0][31:0] ratio;
        logic [NCH-1:0][DELTA_DEPTH-1:0][31:0] hist;
        logic [HW-1:0] ptr;
        logic [31:0] rem;
        logic [31:0] expct;
        logic start;
        logic trip;
        logic blocked;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_t;

    regs_t r;
    regs_t n;
    logic [NCH-1:0][31:0] inp;
    logic [NCH-1:0][31:0] sc_c;
    logic [NCH-1:0] ful;
    logic pick_any;
    logic wr_en;
    logic [2:0] grp;
    logic [1:0] ch;
    logic [4:0] fld;
    logic in_ch;
    logic mapped;
    logic [31:0] rd;

    function automatic logic [31:0] scale_val(input logic signed [31:0] v,
                                               input logic signed [31:0] m);
        logic signed [63:0] p;
        p = 64'(v) * 64'(m);
        scale_val = 32'(p >>> MULT_FRAC);
    endfunction

    function automatic logic [31:0] ratio_of(input logic signed [31:0] v,
                                              input logic signed [31:0] pk);
        logic signed [63:0] q;
        q = 64'sd0;
        if (pk != 32'sh0)
        begin
            q = (64'(v) * RATIO_ONE) / 64'(pk);
        end
        ratio_of = 32'(q);
    endfunction

    function automatic logic [31:0] ticks_ms(input logic [18:0] t);
        ticks_ms = 32'(t) * 32'(PROG_CYCLE_MS);
    endfunction

    assign inp = {calculated_magnitude, meas_value_c, meas_value_b, meas_value_a};

    // Scaled values are live so comparisons see this cycle's sample
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            sc_c[i] = scale_val(inp[i], r.mult[i]);
        end
    end

    for (genvar g = 0; g < NCH; g++)
    begin : g_cmp
        stage_comparator u_cmp (
            .mode(r.mode[g]),
            .pickup(r.pick[g]),
            .hyst(r.hyst[g]),
            .limit(r.lim[g]),
            .value(sc_c[g]),
            .old_value(r.hist[g][r.ptr]),
            .active(r.act[g]),
            .fulfilled(ful[g])
        );
    end

    assign pick_any = |(ful & r.en);

    // APB decode
    assign grp = paddr[7:5];
    assign ch = 2'(grp - 3'h1);
    assign fld = paddr[4:0];
    assign in_ch = (paddr >= A_CH_BASE) && (paddr < A_CH_END);
    assign mapped = (paddr[1:0] == 2'h0)
                    && ((paddr <= A_EXPECT) || (in_ch && fld <= F_RATIO));
    assign wr_en = psel && penable && pwrite && r.pready;

    always_comb
    begin
        rd = 32'h0000_0000;
        if (in_ch)
        begin
            case (fld)
                F_MODE: rd = {29'h0, r.mode[ch]};
                F_PICK: rd = r.pick[ch];
                F_HYST: rd = r.hyst[ch];
                F_MULT: rd = r.mult[ch];
                F_LIM: rd = r.lim[ch];
                F_SCALED: rd = r.scaled[ch];
                F_RATIO: rd = r.ratio[ch];
                default: rd = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (paddr)
                A_CTRL: rd = {28'h0, r.en};
                A_OPDLY: rd = {13'h0, r.op_dly};
                A_RELDLY: rd = {13'h0, r.rel_dly};
                A_STATUS: rd = {26'h0, r.act, r.st};
                A_REMAIN: rd = r.rem;
                A_EXPECT: rd = r.expct;
                default: rd = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        n = r;
        // Zero-wait slave: answer in the first access cycle
        n.pready = psel && !penable;
        n.pslverr = psel && !penable && !mapped;
        if (psel && !penable)
        begin
            n.prdata = mapped ? rd : 32'h0000_0000;
        end
        if (wr_en && mapped)
        begin
            if (in_ch)
            begin
                case (fld)
                    F_MODE: n.mode[ch] = pwdata[2:0];
                    F_PICK: n.pick[ch] = pwdata;
                    F_HYST: n.hyst[ch] = pwdata;
                    F_MULT: n.mult[ch] = pwdata;
                    F_LIM: n.lim[ch] = pwdata;
                    default: n.mode[ch] = r.mode[ch];
                endcase
            end
            else
            begin
                case (paddr)
                    A_CTRL: n.en = pwdata[3:0];
                    // Delays clamp at the longest setting
                    A_OPDLY: n.op_dly = (pwdata > 32'(MAX_DLY_TICKS))
                                        ? MAX_DLY_TICKS : pwdata[18:0];
                    A_RELDLY: n.rel_dly = (pwdata > 32'(MAX_DLY_TICKS))
                                         ? MAX_DLY_TICKS : pwdata[18:0];
                    default: n.en = r.en;
                endcase
            end
        end

        // Processing cycle divider
        n.tick = 1'b0;
        if (32'(r.div) >= 32'(CYCLE_CLKS - 1))
        begin
            n.div = 18'h0;
            n.tick = 1'b1;
        end
        else
        begin
            n.div = r.div + 18'h1;
        end

        if (r.tick)
        begin
            n.act = ful;
            n.ptr = (32'(r.ptr) == DELTA_DEPTH - 1) ? '0 : HW'(r.ptr + 1'b1);
            for (int i = 0; i < NCH; i++)
            begin
                n.scaled[i] = sc_c[i];
                n.ratio[i] = ratio_of(sc_c[i], r.pick[i]);
                n.hist[i][r.ptr] = sc_c[i];
            end
            // Blocking is looked at once per processing cycle only
            case (r.st)
                ST_NORMAL:
                begin
                    if (pick_any)
                    begin
                        n.rel_cnt = r.rel_dly;
                        n.op_cnt = r.op_dly;
                        if (block_in)
                        begin
                            n.st = ST_BLOCKED;
                        end
                        else if (r.op_dly == 19'h0)
                        begin
                            n.st = ST_TRIP;
                        end
                        else
                        begin
                            n.st = ST_START;
                        end
                    end
                end
                ST_START, ST_TRIP:
                begin
                    if (block_in)
                    begin
                        n.st = ST_BLOCKED;
                    end
                    else if (!pick_any)
                    begin
                        if (r.rel_cnt <= 19'h1)
                        begin
                            n.st = ST_NORMAL;
                        end
                        else
                        begin
                            n.rel_cnt = r.rel_cnt - 19'h1;
                        end
                    end
                    else
                    begin
                        n.rel_cnt = r.rel_dly;
                        if (r.st == ST_START)
                        begin
                            if (r.op_cnt <= 19'h1)
                            begin
                                n.st = ST_TRIP;
                            end
                            n.op_cnt = r.op_cnt - 19'h1;
                        end
                    end
                end
                ST_BLOCKED:
                begin
                    if (!block_in || !pick_any)
                    begin
                        n.st = ST_NORMAL;
                    end
                end
                default: n.st = ST_NORMAL;
            endcase
        end

        n.start = (n.st == ST_START);
        n.trip = (n.st == ST_TRIP);
        n.blocked = (n.st == ST_BLOCKED);
        n.rem = (n.st == ST_START) ? ticks_ms(n.op_cnt) : 32'h0;
        n.expct = (n.st == ST_START || n.st == ST_TRIP)
                  ? ticks_ms(n.op_dly) : 32'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.op_dly <= OP_DLY_RST;
            r.rel_dly <= REL_DLY_RST;
            r.en <= EN_RST;
            r.pick <= {NCH{PICK_RST}};
            r.hyst <= {NCH{HYST_RST}};
            r.mult <= {NCH{MULT_RST}};
            r.lim <= {NCH{LIM_RST}};
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign condition = r.st;
    assign start_out = r.start;
    assign trip_out = r.trip;
    assign blocked_out = r.blocked;
    assign remaining_ms = r.rem;
    assign expected_ms = r.expct;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_start_tick;
        r.tick && r.st == ST_START && pick_any && !block_in;
    endsequence

    property p_block_code;
        r.tick && r.st == ST_NORMAL && pick_any && block_in |=> condition == 2'h3;
    endproperty
    a_block_code: assert property (p_block_code) else $error("no blocked code");

    property p_count_down;
        s_start_tick and (r.op_cnt > 19'h1) |=> remaining_ms == $past(remaining_ms) - 32'd5;
    endproperty
    a_count_down: assert property (p_count_down) else $error("remaining wrong");

    property p_expect;
        start_out |-> expected_ms == 32'(r.op_dly) * 32'd5;
    endproperty
    a_expect: assert property (p_expect) else $error("expected time wrong");

    property p_trip;
        s_start_tick and (r.op_cnt == 19'h1) |=> trip_out && !start_out;
    endproperty
    a_trip: assert property (p_trip) else $error("trip late");

    property p_hold_release;
        r.tick && trip_out && !pick_any && !block_in && r.rel_cnt > 19'h1 |=> trip_out;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("early release");

    property p_start_ok;
        r.tick && r.st == ST_NORMAL && pick_any && !block_in && r.op_dly != 19'h0
            |=> start_out ##1 start_out;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("start missing");

    property p_block_resets;
        r.tick && start_out && block_in |=> !start_out && blocked_out;
    endproperty
    a_block_resets: assert property (p_block_resets) else $error("start kept");

    property p_over_mode;
        r.tick && r.mode[0] == 3'h0 && !r.act[0]
            && $signed(sc_c[0]) > $signed(r.pick[0]) |=> r.act[0];
    endproperty
    a_over_mode: assert property (p_over_mode) else $error("over not seen");
endmodule

// ### tb/meas_source.sv
/*
 Model of the measurement subsystem and blocking source feeding the stage.
 Assumes the bench calls its tasks from the pclk domain.
*/
module meas_source
(
    input wire logic pclk,
    output logic signed [31:0] meas_value_a,
    output logic signed [31:0] meas_value_b,
    output logic signed [31:0] meas_value_c,
    output logic signed [31:0] calculated_magnitude,
    output logic block_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Values are held between updates, as the stage expects
    initial
    begin
        meas_value_a = 32'sh0;
        meas_value_b = 32'sh0;
        meas_value_c = 32'sh0;
        calculated_magnitude = 32'sh0;
        block_in = 1'b0;
    end

    // Changes land on a rising edge only, so no half-updated set is sampled
    task automatic set_meas(input int ch, input logic signed [31:0] v);
        @(posedge pclk);
        case (ch)
            0: meas_value_a <= v;
            1: meas_value_b <= v;
            2: meas_value_c <= v;
            default: calculated_magnitude <= v;
        endcase
    endtask

    task automatic set_block(input logic b);
        @(posedge pclk);
        block_in <= b;
    endtask
endmodule

// ### tb/programmable_stage_function_tb.sv
/*
 Self-checking bench of the programmable stage: APB master, status and timing.
 Assumes a shortened processing tick of 8 pclk cycles.
*/
module programmable_stage_function_tb;
    import pstage_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CYC = 8;
    localparam logic [7:0] CH0 = A_CH_BASE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic signed [31:0] meas_value_a, meas_value_b, meas_value_c, calculated_magnitude;
    logic block_in, start_out, trip_out, blocked_out;
    cond_t condition;
    logic [31:0] remaining_ms;
    logic signed [31:0] expected_ms;
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    typedef struct {logic [2:0] m; logic [31:0] pk, lm, v0, v1; logic ex;} mcase_t;
    mcase_t tbl[13] = '{
        '{0, 100, LIM_RST, 0, 200, 1}, '{0, 100, LIM_RST, 0, -200, 0},
        '{1, 100, LIM_RST, 0, -200, 1}, '{2, 100, LIM_RST, 300, 50, 1},
        '{2, 100, 60, 300, 50, 0}, '{3, 100, LIM_RST, 300, -50, 1},
        '{3, 100, LIM_RST, 300, -300, 0}, '{4, 100000, LIM_RST, 1000, 1500, 1},
        '{4, 100000, LIM_RST, 1000, 500, 0}, '{5, 100000, LIM_RST, 1000, 500, 1},
        '{6, 100, LIM_RST, 1000, 1500, 1}, '{6, 100, LIM_RST, 1000, 500, 0},
        '{7, 100, LIM_RST, 1000, 500, 1}};

    always #10 pclk = ~pclk;

    programmable_stage_function #(.CYCLE_CLKS(CYC)) u_programmable_stage_function (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .meas_value_a, .meas_value_b, .meas_value_c, .calculated_magnitude,
        .block_in, .condition, .start_out, .trip_out, .blocked_out, .remaining_ms,
        .expected_ms);

    meas_source u_meas_source (
        .pclk, .meas_value_a, .meas_value_b, .meas_value_c, .calculated_magnitude,
        .block_in);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(er), 32'h0);
    endtask

    task automatic wait_cond(input cond_t c);
        n = 0;
        while (condition !== c && n < 20 * CYC)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(condition), 32'(c));
    endtask

    task automatic t_reset();
        logic [7:0] ad[8] = '{A_OPDLY, A_RELDLY, A_CTRL, CH0 + 8'(F_PICK), CH0 + 8'(F_HYST),
            CH0 + 8'(F_MULT), CH0 + 8'(F_LIM), CH0 + 8'(F_MODE)};
        logic [31:0] ev[8] = '{8, 12, 1, PICK_RST, HYST_RST, MULT_RST, LIM_RST, 0};
        for (int i = 0; i < 8; i++)
            rdchk(ad[i], ev[i]);
        chk(32'(condition), 32'h0);
        apb(1'b1, 8'h40 + 8'(F_HYST), 32'h0001_0000);
        rdchk(CH0 + 8'(F_HYST), HYST_RST);
        apb(1'b0, 8'hFC, 32'h0);
        chk(32'(er), 32'h1);
    endtask

    task automatic t_trip();
        apb(1'b1, A_OPDLY, 32'h4);
        apb(1'b1, A_RELDLY, 32'h3);
        u_meas_source.set_meas(0, 200);
        wait_cond(ST_START);
        chk(remaining_ms, 32'd20);
        chk(expected_ms, 32'd20);
        chk(32'(start_out), 32'h1);
        wait_cond(ST_TRIP);
        chk(32'(n >= 3 * CYC && n <= 5 * CYC), 32'h1);
        chk(32'(trip_out), 32'h1);
        // Inside the 3 % band the pick-up must hold
        u_meas_source.set_meas(0, 99);
        repeat (10 * CYC) @(posedge pclk);
        chk(32'(condition), 32'(ST_TRIP));
        u_meas_source.set_meas(0, 0);
        wait_cond(ST_NORMAL);
        chk(32'(n >= 2 * CYC && n <= 5 * CYC), 32'h1);
    endtask

    task automatic t_scale();
        apb(1'b1, CH0 + 8'(F_MULT), 32'h0002_0000);
        u_meas_source.set_meas(0, 300);
        u_meas_source.set_meas(3, 250);
        repeat (3 * CYC) @(posedge pclk);
        rdchk(CH0 + 8'(F_SCALED), 32'd600);
        apb(1'b1, CH0 + 8'(F_MULT), MULT_RST);
        repeat (3 * CYC) @(posedge pclk);
        rdchk(CH0 + 8'(F_RATIO), 32'd30000);
        rdchk(8'h80 + 8'(F_RATIO), 32'd25000);
        apb(1'b1, CH0 + 8'(F_SCALED), 32'h0);
        rdchk(CH0 + 8'(F_SCALED), 32'd300);
    endtask

    // Each case settles on v0, steps to v1 and watches the channel 0 flag
    task automatic t_modes();
        logic seen;
        foreach (tbl[i])
        begin
            apb(1'b1, CH0 + 8'(F_MODE), 32'(tbl[i].m));
            apb(1'b1, CH0 + 8'(F_PICK), tbl[i].pk);
            apb(1'b1, CH0 + 8'(F_LIM), tbl[i].lm);
            u_meas_source.set_meas(0, tbl[i].v0);
            repeat (7 * CYC) @(posedge pclk);
            u_meas_source.set_meas(0, tbl[i].v1);
            seen = 1'b0;
            repeat (25)
            begin
                apb(1'b0, A_STATUS, 32'h0);
                seen = seen | rd[2];
            end
            chk(32'(seen), 32'(tbl[i].ex));
        end
    endtask

    task automatic t_block();
        apb(1'b1, CH0 + 8'(F_MODE), 32'h0);
        apb(1'b1, CH0 + 8'(F_LIM), LIM_RST);
        u_meas_source.set_meas(0, 0);
        wait_cond(ST_NORMAL);
        // A disabled channel must not pick up at all
        apb(1'b1, A_CTRL, 32'h0);
        u_meas_source.set_meas(0, 200);
        repeat (3 * CYC) @(posedge pclk);
        chk(32'(condition), 32'(ST_NORMAL));
        u_meas_source.set_block(1'b1);
        apb(1'b1, A_CTRL, 32'(EN_RST));
        repeat (3 * CYC) @(posedge pclk);
        chk(32'(condition), 32'(ST_BLOCKED));
        chk(32'(start_out), 32'h0);
        chk(32'(blocked_out), 32'h1);
        u_meas_source.set_block(1'b0);
        wait_cond(ST_START);
        u_meas_source.set_block(1'b1);
        wait_cond(ST_BLOCKED);
        chk(32'(n <= 2 * CYC), 32'h1);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // The whole run needs well under 20000 cycles
    initial
    begin
        #(40_000 * 20);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_trip();
        t_scale();
        t_modes();
        t_block();
        give_verdict();
    end
endmodule
